// ---- hdl/card_port_if.sv ----
// Socket pins between host end and card end
`timescale 1ns/1ps
`default_nettype none
`include "card_port_regs.svh"
interface card_port_if;
  logic [10:0] addr;
  logic ce1_n, ce2_n, oe_n, we_n, reg_n;
  logic io_read_strobe_n, io_write_strobe_n;
  logic [15:0] host_d, card_d;
  logic host_d_oe, card_d_oe;
  logic ready_busy_n, input_acknowledge_n, wide_port_select_n;
  logic card_detect_a_n, card_detect_b_n;
  logic voltage_sense_a_n, voltage_sense_b_n;
  logic pin62_o, pin62_oe;
  logic [15:0] data;
  logic pin62;
  // Resolved levels; pull-ups win when nobody drives
  assign data = host_d_oe ? host_d : (card_d_oe ? card_d : `BUS_IDLE);
  assign pin62 = pin62_oe ? pin62_o : 1'b1;
  modport card (
    input addr, ce1_n, ce2_n, oe_n, we_n, reg_n, io_read_strobe_n,
    input io_write_strobe_n, data,
    output card_d, card_d_oe, ready_busy_n, input_acknowledge_n,
    output wide_port_select_n, card_detect_a_n, card_detect_b_n,
    output voltage_sense_a_n, voltage_sense_b_n, pin62_o, pin62_oe
  );
  modport host (
    output addr, ce1_n, ce2_n, oe_n, we_n, reg_n, io_read_strobe_n,
    output io_write_strobe_n, host_d, host_d_oe,
    input data, ready_busy_n, input_acknowledge_n, wide_port_select_n,
    input card_detect_a_n, card_detect_b_n, pin62
  );
endinterface
`default_nettype wire

// ---- hdl/card_port_pkg.sv ----
// Types shared by both ends of the flash card host port
package card_port_pkg;
  typedef enum logic [1:0] {
    MODE_MEM = 2'b00, MODE_IO = 2'b01, MODE_IDE = 2'b10
  } mode_t;
  typedef enum logic [1:0] {
    SP_COMMON = 2'b00, SP_ATTR = 2'b01, SP_IO = 2'b10, SP_TASK = 2'b11
  } space_t;
  typedef enum logic [1:0] {
    LANE_WORD = 2'b00, LANE_EVEN = 2'b01, LANE_ODD = 2'b10, LANE_HIGH = 2'b11
  } lane_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00, H_SETUP = 2'b01, H_STROBE = 2'b10, H_HOLD = 2'b11
  } host_state_t;
endpackage

// ---- hdl/card_port_regs.svh ----
// Pin-level constants for the flash card host port
`ifndef CARD_PORT_REGS_SVH
`define CARD_PORT_REGS_SVH
`define DATA_W 16
`define ADDR_W 11
`define CIS_BYTES 256
`define CFG_OPT_ADDR 11'h200
`define CFG_IO_BIT 0
`define TF_DATA_REG 3'h0
`define INIT_TIME_NS 1000
`define CLK_MHZ 125
`define INIT_CYCLES ((`INIT_TIME_NS * `CLK_MHZ + 999) / 1000)
`define STROBE_CYCLES 4
`define BUS_IDLE 16'hFFFF
`endif

// ---- hdl/flash_card_end.sv ----
// Card end of the socket: mode decode, strobes, lanes, CARD_INFO_STRUCTURE, write buffer
`timescale 1ns/1ps
`default_nettype none
`include "card_port_regs.svh"
module flash_card_end #(
  parameter int INIT_CYCLES = `INIT_CYCLES,
  parameter bit FIXED_MEDIA = 1'b0
) (
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // Socket pins
  card_port_if.card pins,
  // Write stream toward the controller
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output logic [10:0] o_wr_addr,
  output card_port_pkg::space_t o_wr_space,
  output logic [15:0] o_wr_data,
  output logic [1:0] o_wr_bytes,
  // Read lookup, answered in the same cycle
  output logic [10:0] o_rd_addr,
  output card_port_pkg::space_t o_rd_space,
  input wire logic [15:0] i_rd_data,
  // CARD_INFO_STRUCTURE loading
  input wire logic i_cis_load,
  input wire logic [7:0] i_cis_addr,
  input wire logic [7:0] i_cis_byte,
  // Status
  output card_port_pkg::mode_t o_mode,
  output logic o_media_fixed
);
  import card_port_pkg::*;

  logic [15:0] init_cnt;
  logic busy;
  logic strap_taken;
  logic ide;
  logic io_cfg;
  logic [7:0] cis_mem [0:`CIS_BYTES-1];
  logic [15:0] rd_q;
  logic prev_we_n, prev_iow_n;
  logic lat_ok;
  logic [10:0] lat_addr;
  space_t lat_space;
  logic [15:0] lat_data;
  logic [1:0] lat_bytes;
  logic [10:0] buf_addr [0:1];
  space_t buf_space [0:1];
  logic [15:0] buf_data [0:1];
  logic [1:0] buf_bytes [0:1];
  logic wp, rp;
  logic [1:0] count;

  // Personality
  mode_t mode;
  assign mode = ide ? MODE_IDE : (io_cfg ? MODE_IO : MODE_MEM);
  assign o_mode = mode;
  assign o_media_fixed = FIXED_MEDIA;

  // Select, lanes and effective address
  wire sel = !pins.ce1_n || !pins.ce2_n;
  wire io_ok = (mode != MODE_MEM);
  wire [10:0] ide_addr = {7'h00, !pins.ce2_n, pins.addr[2:0]};
  wire tf_data = pins.ce2_n && (pins.addr[2:0] == `TF_DATA_REG);
  lane_t pc_lane;
  assign pc_lane = (!pins.ce1_n && !pins.ce2_n) ? LANE_WORD :
                   (!pins.ce1_n ? (pins.addr[0] ? LANE_ODD : LANE_EVEN) : LANE_HIGH);
  lane_t lane;
  assign lane = (mode == MODE_IDE) ? (tf_data ? LANE_WORD : LANE_EVEN) : pc_lane;
  wire [10:0] eff_addr = (mode == MODE_IDE) ? ide_addr : pins.addr;

  // Read decode
  wire io_rd = io_ok && sel && !pins.io_read_strobe_n;
  wire mem_rd = (mode == MODE_MEM) && sel && !pins.oe_n;
  wire attr_rd = (mode == MODE_IO) && sel && !pins.oe_n && !pins.reg_n;
  wire read_act = (io_rd || mem_rd || attr_rd) && !busy;
  space_t rd_space;
  assign rd_space = io_rd ? ((mode == MODE_IDE) ? SP_TASK : SP_IO) :
                    (pins.reg_n ? SP_COMMON : SP_ATTR);
  assign o_rd_addr = eff_addr;
  assign o_rd_space = rd_space;
  wire cis_hit = (rd_space == SP_ATTR) && !eff_addr[0] && (eff_addr[10:9] == 2'b00);
  wire cfg_hit = (rd_space == SP_ATTR) && (eff_addr == `CFG_OPT_ADDR);
  wire [15:0] src = cis_hit ? {8'h00, cis_mem[eff_addr[8:1]]} :
                    cfg_hit ? {15'h0000, io_cfg} :
                    (rd_space == SP_ATTR) ? 16'h0000 : i_rd_data;
  logic [15:0] rd_lanes;
  always_comb begin
    unique case (lane)
      LANE_WORD: rd_lanes = src;
      LANE_EVEN: rd_lanes = {8'hFF, src[7:0]};
      LANE_ODD: rd_lanes = {8'hFF, src[15:8]};
      LANE_HIGH: rd_lanes = {src[15:8], 8'hFF};
    endcase
  end

  // Bus driven only during a selected read of this mode
  assign pins.card_d = rd_q;
  assign pins.card_d_oe = read_act;
  assign pins.input_acknowledge_n = !((mode == MODE_IO) && io_rd);

  // Write decode; memory strobe is for data only in memory mode
  wire we_rise = !prev_we_n && pins.we_n;
  wire iow_rise = !prev_iow_n && pins.io_write_strobe_n;
  wire we_ok = (mode == MODE_MEM) || ((mode == MODE_IO) && !pins.reg_n);
  wire we_low = we_ok && !pins.we_n && sel;
  wire iow_low = io_ok && !pins.io_write_strobe_n && sel;
  space_t wr_space;
  assign wr_space = iow_low ? ((mode == MODE_IDE) ? SP_TASK : SP_IO) :
                    (pins.reg_n ? SP_COMMON : SP_ATTR);
  logic [15:0] wr_lanes;
  logic [1:0] wr_bytes;
  always_comb begin
    unique case (lane)
      LANE_WORD: begin
        wr_lanes = pins.data;
        wr_bytes = 2'b11;
      end
      LANE_EVEN: begin
        wr_lanes = {8'h00, pins.data[7:0]};
        wr_bytes = 2'b01;
      end
      LANE_ODD: begin
        wr_lanes = {pins.data[7:0], 8'h00};
        wr_bytes = 2'b10;
      end
      LANE_HIGH: begin
        wr_lanes = {pins.data[15:8], 8'h00};
        wr_bytes = 2'b10;
      end
    endcase
  end
  wire commit = (we_rise || iow_rise) && lat_ok;
  wire cfg_wr = commit && (lat_space == SP_ATTR) && (lat_addr == `CFG_OPT_ADDR);
  wire push = commit && (lat_space != SP_ATTR) && (count != 2'd2);
  wire pop = o_wr_valid && i_wr_ready;

  // Fixed-level pins, plus pin62 which follows mode and buffer count
  assign pins.card_detect_a_n = 1'b0;
  assign pins.card_detect_b_n = 1'b0;
  assign pins.voltage_sense_a_n = 1'b0;
  assign pins.voltage_sense_b_n = 1'b1;
  assign pins.pin62_o = (mode != MODE_IDE);
  assign pins.pin62_oe = (mode != MODE_IDE) || (count != 2'd0);
  // In memory mode busy also covers a full buffer, which is how back-pressure reaches the host
  assign pins.ready_busy_n = (mode == MODE_MEM) ? !(busy || count == 2'd2) : 1'b1;
  assign pins.wide_port_select_n = (mode == MODE_IO) ? !sel :
                                   ((mode == MODE_IDE) ? 1'b1 : busy);

  // Buffer outputs come straight from the entry registers
  assign o_wr_valid = (count != 2'd0);
  assign o_wr_addr = buf_addr[rp];
  assign o_wr_space = buf_space[rp];
  assign o_wr_data = buf_data[rp];
  assign o_wr_bytes = buf_bytes[rp];

  // Init counter; strap sampled once after reset release
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      init_cnt <= 16'h0000;
      busy <= 1'b1;
      strap_taken <= 1'b0;
      ide <= 1'b0;
    end else if (i_clk_en) begin
      if (!strap_taken) begin
        strap_taken <= 1'b1;
        ide <= !pins.oe_n;
      end
      if (init_cnt >= 16'(INIT_CYCLES - 1)) begin
        busy <= 1'b0;
      end else begin
        init_cnt <= init_cnt + 16'h0001;
      end
    end
  end

  // Configuration option and CARD_INFO_STRUCTURE store
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      io_cfg <= 1'b0;
    end else if (i_clk_en && cfg_wr) begin
      io_cfg <= lat_data[`CFG_IO_BIT];
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_clk_en && i_cis_load) begin
      cis_mem[i_cis_addr] <= i_cis_byte;
    end
  end

  // Read data register and strobe latches; data latched while strobe low
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      rd_q <= `BUS_IDLE;
      prev_we_n <= 1'b1;
      prev_iow_n <= 1'b1;
      lat_ok <= 1'b0;
      lat_addr <= 11'h000;
      lat_space <= SP_COMMON;
      lat_data <= 16'h0000;
      lat_bytes <= 2'b00;
    end else if (i_clk_en) begin
      rd_q <= rd_lanes;
      prev_we_n <= pins.we_n;
      prev_iow_n <= pins.io_write_strobe_n;
      if (we_low || iow_low) begin
        lat_ok <= !busy;
        lat_addr <= eff_addr;
        lat_space <= wr_space;
        lat_data <= wr_lanes;
        lat_bytes <= wr_bytes;
      end else if (commit || (pins.we_n && pins.io_write_strobe_n)) begin
        lat_ok <= 1'b0;
      end
    end
  end

  // Two-entry write buffer
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      wp <= 1'b0;
      rp <= 1'b0;
      count <= 2'd0;
    end else if (i_clk_en) begin
      if (push) begin
        buf_addr[wp] <= lat_addr;
        buf_space[wp] <= lat_space;
        buf_data[wp] <= lat_data;
        buf_bytes[wp] <= lat_bytes;
        wp <= !wp;
      end
      if (pop) begin
        rp <= !rp;
      end
      count <= 2'(count + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule
`default_nettype wire

// ---- hdl/flash_host_end.sv ----
// Host end of the socket: runs one strobe cycle per command
`timescale 1ns/1ps
`default_nettype none
`include "card_port_regs.svh"
module flash_host_end #(
  parameter int STROBE_CYCLES = `STROBE_CYCLES
) (
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  // Socket pins
  card_port_if.host pins,
  // Command request
  input wire card_port_pkg::mode_t i_mode,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic i_cmd_write,
  input wire card_port_pkg::space_t i_cmd_space,
  input wire card_port_pkg::lane_t i_cmd_lane,
  input wire logic [10:0] i_cmd_addr,
  input wire logic [15:0] i_cmd_data,
  // Read answer
  output logic o_rsp_valid,
  output logic [15:0] o_rsp_data,
  // Status
  output logic o_card_present
);
  import card_port_pkg::*;

  host_state_t st;
  logic [7:0] cnt;
  logic c_wr;
  space_t c_space;
  lane_t c_lane;
  logic [10:0] c_addr;
  logic [15:0] c_data;

  wire ide = (i_mode == MODE_IDE);
  wire act = (st != H_IDLE);
  wire strobe = (st == H_STROBE);
  wire io_sp = (c_space == SP_IO) || (c_space == SP_TASK);
  // IDE register selects; task registers other than data are bytewide
  wire cs1 = c_addr[3];
  wire tf_word = !cs1 && (c_addr[2:0] == `TF_DATA_REG);
  lane_t lane;
  assign lane = ide ? (tf_word ? LANE_WORD : LANE_EVEN) : c_lane;

  // Outside IDE mode, commands wait while the card reports busy
  assign o_cmd_ready = (st == H_IDLE) && (ide || pins.ready_busy_n);
  assign o_card_present = !ide && !pins.card_detect_a_n && !pins.card_detect_b_n;

  // Pin drive
  assign pins.addr = ide ? {8'h00, c_addr[2:0]} :
                     {c_addr[10:1], c_lane == LANE_ODD};
  assign pins.ce1_n = ide ? !(act && !cs1) : !(act && (c_lane != LANE_HIGH));
  assign pins.ce2_n = ide ? !(act && cs1) :
                      !(act && (c_lane == LANE_WORD || c_lane == LANE_HIGH));
  assign pins.reg_n = !(act && !ide && (c_space == SP_ATTR || c_space == SP_IO));
  assign pins.oe_n = ide ? 1'b0 : !(strobe && !c_wr && !io_sp);
  assign pins.we_n = ide ? 1'b1 : !(strobe && c_wr && !io_sp);
  assign pins.io_read_strobe_n = !(strobe && !c_wr && io_sp);
  assign pins.io_write_strobe_n = !(strobe && c_wr && io_sp);
  // Data held through the hold cycle past the trailing edge
  assign pins.host_d_oe = act && c_wr;
  assign pins.host_d = (lane == LANE_HIGH || lane == LANE_WORD) ? c_data :
                       ((lane == LANE_ODD) ? {8'hFF, c_data[15:8]} : {8'hFF, c_data[7:0]});

  // Read lanes back into word position
  logic [15:0] rd_word;
  always_comb begin
    unique case (lane)
      LANE_WORD: rd_word = pins.data;
      LANE_EVEN: rd_word = {8'h00, pins.data[7:0]};
      LANE_ODD: rd_word = {pins.data[7:0], 8'h00};
      LANE_HIGH: rd_word = {pins.data[15:8], 8'h00};
    endcase
  end

  // Cycle sequencer
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      st <= H_IDLE;
      cnt <= 8'h00;
      c_wr <= 1'b0;
      c_space <= SP_COMMON;
      c_lane <= LANE_WORD;
      c_addr <= 11'h000;
      c_data <= 16'h0000;
      o_rsp_valid <= 1'b0;
      o_rsp_data <= 16'h0000;
    end else if (i_clk_en) begin
      o_rsp_valid <= 1'b0;
      unique case (st)
        H_IDLE: begin
          if (i_cmd_valid && o_cmd_ready) begin
            c_wr <= i_cmd_write;
            c_space <= i_cmd_space;
            c_lane <= i_cmd_lane;
            c_addr <= i_cmd_addr;
            c_data <= i_cmd_data;
            st <= H_SETUP;
          end
        end
        H_SETUP: begin
          cnt <= 8'h00;
          st <= H_STROBE;
        end
        H_STROBE: begin
          cnt <= cnt + 8'h01;
          if (cnt == 8'(STROBE_CYCLES - 1)) begin
            if (!c_wr) begin
              o_rsp_valid <= 1'b1;
              o_rsp_data <= rd_word;
            end
            st <= H_HOLD;
          end
        end
        H_HOLD: begin
          st <= H_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- sim/card_port_props.sv ----
// Socket-pin checks for the host end and card end of the flash card port
`timescale 1ns/1ps
`default_nettype none
module card_port_props (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Host-driven pins
  input wire logic ce1_n,
  input wire logic ce2_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic host_d_oe,
  // Card-driven pins and resolved lines
  input wire logic card_d_oe,
  input wire logic [15:0] data,
  input wire logic ready_busy_n,
  input wire logic input_acknowledge_n,
  input wire logic wide_port_select_n,
  input wire logic card_detect_a_n,
  input wire logic card_detect_b_n,
  input wire logic pin62
);
  logic strap_pending;
  logic ide;
  logic selected;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  assign selected = !ce1_n || !ce2_n;
  // The card takes its IDE strap once, at the first edge after reset release
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      strap_pending <= 1'b1;
      ide <= 1'b0;
    end else if (strap_pending) begin
      strap_pending <= 1'b0;
      ide <= !oe_n;
    end
  end
  AST_CARD_DETECT: assert property (!card_detect_a_n && !card_detect_b_n)
    else $error("card detect pin not low");
  AST_PIN62_HIGH: assert property (!strap_pending && !ide |-> pin62)
    else $error("status line low outside IDE mode");
  AST_BUS_RELEASE: assert property (card_d_oe |-> selected && (!oe_n || !io_read_strobe_n))
    else $error("card drives data without a selected read");
  AST_NO_CONTENTION: assert property (!(card_d_oe && host_d_oe))
    else $error("host and card drive data together");
  AST_INPUT_ACK: assert property (!input_acknowledge_n |-> !io_read_strobe_n && selected && card_d_oe)
    else $error("input acknowledge without a driven read");
  AST_BUSY_AFTER_RESET: assert property ($rose(i_resetn) && oe_n |->
    !ready_busy_n [*3] ##[1:8] ready_busy_n)
    else $error("busy after reset wrong");
  AST_WIDE_IDE: assert property (ide |-> wide_port_select_n)
    else $error("wide port select driven in IDE mode");
  AST_WE_IDE: assert property (ide |-> we_n)
    else $error("memory write strobe used in IDE mode");
  AST_STROBE_SELECT: assert property (!we_n || !io_write_strobe_n || !io_read_strobe_n |-> selected)
    else $error("strobe without card select");
  AST_WRITE_HOLD: assert property ($rose(io_write_strobe_n) |-> host_d_oe && $stable(data))
    else $error("write data not held through trailing edge");
  AST_READ_WIDTH: assert property ($fell(io_read_strobe_n) |-> !io_read_strobe_n [*3])
    else $error("read strobe too short");
endmodule
`default_nettype wire

// ---- sim/flash_card_host_pin_interface_tb.sv ----
// Self-checking bench: host end and card end joined through the socket pins
`timescale 1ns/1ps
`default_nettype none
module flash_card_host_pin_interface_tb;
  import card_port_pkg::*;
  logic i_clk_sys, i_resetn, cmd_valid, cmd_write, wr_ready, cis_load, clk_en;
  mode_t host_mode, card_mode;
  space_t cmd_space, wr_space, rd_space;
  lane_t cmd_lane;
  logic [10:0] cmd_addr, wr_addr, rd_addr;
  logic [15:0] cmd_data, wr_data, rsp_data, rd_data, got;
  logic [7:0] cis_addr, cis_byte;
  logic [1:0] wr_bytes;
  logic cmd_ready, rsp_valid, wr_valid, card_present, media_fixed;
  int num_errors, compares;
  card_port_if pins_if();
  // Controller read model: a pattern of address and space, so a wrong space shows in the data
  assign rd_data = {rd_addr[7:0] ^ 8'h5A, rd_addr[7:0] ^ 8'h3C ^ {6'h00, rd_space}};
  flash_card_end #(.INIT_CYCLES(4), .FIXED_MEDIA(1'b0)) flash_card_end_inst (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_clk_en(clk_en), .pins(pins_if.card),
    .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr_addr(wr_addr), .o_wr_space(wr_space),
    .o_wr_data(wr_data), .o_wr_bytes(wr_bytes), .o_rd_addr(rd_addr), .o_rd_space(rd_space),
    .i_rd_data(rd_data), .i_cis_load(cis_load), .i_cis_addr(cis_addr), .i_cis_byte(cis_byte),
    .o_mode(card_mode), .o_media_fixed(media_fixed));
  flash_host_end #(.STROBE_CYCLES(4)) flash_host_end_inst (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_clk_en(clk_en), .pins(pins_if.host),
    .i_mode(host_mode), .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready),
    .i_cmd_write(cmd_write), .i_cmd_space(cmd_space), .i_cmd_lane(cmd_lane),
    .i_cmd_addr(cmd_addr), .i_cmd_data(cmd_data), .o_rsp_valid(rsp_valid),
    .o_rsp_data(rsp_data), .o_card_present(card_present));
  card_port_props card_port_props_inst (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .ce1_n(pins_if.ce1_n), .ce2_n(pins_if.ce2_n),
    .oe_n(pins_if.oe_n), .we_n(pins_if.we_n), .io_read_strobe_n(pins_if.io_read_strobe_n),
    .io_write_strobe_n(pins_if.io_write_strobe_n), .host_d_oe(pins_if.host_d_oe),
    .card_d_oe(pins_if.card_d_oe), .data(pins_if.data), .ready_busy_n(pins_if.ready_busy_n),
    .input_acknowledge_n(pins_if.input_acknowledge_n),
    .wide_port_select_n(pins_if.wide_port_select_n), .card_detect_a_n(pins_if.card_detect_a_n),
    .card_detect_b_n(pins_if.card_detect_b_n), .pin62(pins_if.pin62));
  // 125 MHz system clock
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check_word(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic check_flag(input logic g, input logic e);
    check_word({15'h0000, g}, {15'h0000, e});
  endtask
  // Reset is synchronous; the host mode is set first so the IDE strap is seen at release
  task automatic do_reset(input mode_t m);
    host_mode = m;
    i_resetn = 1'b0;
    repeat (20) @(posedge i_clk_sys);
    #1;
    i_resetn = 1'b1;
  endtask
  // One command; held until the edge that takes it
  task automatic host_cmd(input logic w, input space_t s, input lane_t l, input logic [10:0] a,
                          input logic [15:0] d);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_space = s;
    cmd_lane = l;
    cmd_addr = a;
    cmd_data = d;
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    check_flag(cmd_ready, 1'b1);
    @(posedge i_clk_sys);
    #1;
    cmd_valid = 1'b0;
  endtask
  task automatic host_read(input space_t s, input lane_t l, input logic [10:0] a);
    int n;
    n = 0;
    host_cmd(1'b0, s, l, a, 16'h0000);
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    check_flag(rsp_valid, 1'b1);
    got = rsp_data;
  endtask
  // Wait for the head of the write stream, compare it, then accept it
  task automatic pop(input space_t s, input logic [1:0] b, input logic [15:0] m,
                     input logic [15:0] d);
    int n;
    n = 0;
    while (wr_valid !== 1'b1 && n < 40) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    check_flag(wr_valid, 1'b1);
    check_word({14'h0000, wr_space}, {14'h0000, s});
    check_word({14'h0000, wr_bytes}, {14'h0000, b});
    check_word(wr_data & m, d);
    got = {5'h00, wr_addr};
    wr_ready = 1'b1;
    @(posedge i_clk_sys);
    #1;
    wr_ready = 1'b0;
  endtask
  // A refused write leaves the stream empty well past the strobe
  task automatic no_word();
    repeat (12) @(posedge i_clk_sys);
    #1;
    check_flag(wr_valid, 1'b0);
  endtask
  // Watchdog, over fifty times the expected run
  initial begin
    #300000;
    num_errors++;
    print_verdict();
  end
  initial begin
    {i_resetn, cmd_valid, cmd_write, wr_ready, cis_load} = 5'h00;
    clk_en = 1'b1;
    cmd_space = SP_COMMON;
    cmd_lane = LANE_WORD;
    {cmd_addr, cmd_data, cis_addr, cis_byte} = 43'h0;
    host_mode = MODE_MEM;
    num_errors = 0;
    compares = 0;
    do_reset(MODE_MEM);
    check_word({14'h0000, card_mode}, {14'h0000, MODE_MEM});
    check_flag(media_fixed, 1'b0);
    // Boundary bytes of the information structure
    cis_load = 1'b1;
    cis_addr = 8'h00;
    cis_byte = 8'h19;
    @(posedge i_clk_sys);
    #1;
    cis_addr = 8'hFF;
    cis_byte = 8'hE7;
    @(posedge i_clk_sys);
    #1;
    cis_load = 1'b0;
    host_read(SP_ATTR, LANE_EVEN, 11'h000);
    check_word({8'h00, got[7:0]}, 16'h0019);
    host_read(SP_ATTR, LANE_EVEN, 11'h1FE);
    check_word({8'h00, got[7:0]}, 16'h00E7);
    check_flag(card_present, 1'b1);
    check_flag(pins_if.pin62, 1'b1);
    host_cmd(1'b1, SP_COMMON, LANE_WORD, 11'h010, 16'h1234);
    pop(SP_COMMON, 2'b11, 16'hFFFF, 16'h1234);
    check_word(got, 16'h0010);
    host_cmd(1'b1, SP_COMMON, LANE_HIGH, 11'h013, 16'hAB00);
    pop(SP_COMMON, 2'b10, 16'hFF00, 16'hAB00);
    // Odd byte carried on the low lane by an 8-bit host
    host_cmd(1'b1, SP_COMMON, LANE_ODD, 11'h015, 16'hCD00);
    pop(SP_COMMON, 2'b10, 16'hFF00, 16'hCD00);
    check_word(got, 16'h0015);
    // Receiver stalls: two words fill the buffer, busy shows, order kept
    host_cmd(1'b1, SP_COMMON, LANE_WORD, 11'h020, 16'h1111);
    host_cmd(1'b1, SP_COMMON, LANE_WORD, 11'h022, 16'h2222);
    repeat (12) @(posedge i_clk_sys);
    #1;
    check_flag(pins_if.ready_busy_n, 1'b0);
    pop(SP_COMMON, 2'b11, 16'hFFFF, 16'h1111);
    pop(SP_COMMON, 2'b11, 16'hFFFF, 16'h2222);
    host_read(SP_COMMON, LANE_WORD, 11'h010);
    check_word(got, 16'h4A2C);
    host_read(SP_COMMON, LANE_EVEN, 11'h020);
    check_word({8'h00, got[7:0]}, 16'h001C);
    host_read(SP_COMMON, LANE_ODD, 11'h021);
    check_word({got[15:8], 8'h00}, 16'h7B00);
    host_cmd(1'b1, SP_IO, LANE_WORD, 11'h008, 16'h5555);
    no_word();
    host_read(SP_IO, LANE_WORD, 11'h008);
    check_word(got, 16'hFFFF);
    // Configuration write selects the I/O personality
    host_cmd(1'b1, SP_ATTR, LANE_EVEN, 11'h200, 16'h0001);
    repeat (10) @(posedge i_clk_sys);
    #1;
    check_word({14'h0000, card_mode}, {14'h0000, MODE_IO});
    host_mode = MODE_IO;
    host_read(SP_ATTR, LANE_EVEN, 11'h200);
    check_word({8'h00, got[7:0]}, 16'h0001);
    host_cmd(1'b1, SP_IO, LANE_WORD, 11'h008, 16'hBEEF);
    // Enable low freezes both ends mid-cycle; the write only lands once it runs again
    clk_en = 1'b0;
    no_word();
    clk_en = 1'b1;
    pop(SP_IO, 2'b11, 16'hFFFF, 16'hBEEF);
    host_cmd(1'b1, SP_COMMON, LANE_WORD, 11'h010, 16'h9999);
    no_word();
    host_read(SP_IO, LANE_WORD, 11'h008);
    check_word(got, 16'h5236);
    check_flag(pins_if.pin62, 1'b1);
    check_flag(card_present, 1'b1);
    // Second reset with the IDE strap
    do_reset(MODE_IDE);
    repeat (3) @(posedge i_clk_sys);
    #1;
    check_word({14'h0000, card_mode}, {14'h0000, MODE_IDE});
    check_flag(card_present, 1'b0);
    host_cmd(1'b1, SP_TASK, LANE_EVEN, 11'h002, 16'h0077);
    pop(SP_TASK, 2'b01, 16'h00FF, 16'h0077);
    host_cmd(1'b1, SP_TASK, LANE_WORD, 11'h000, 16'hCAFE);
    pop(SP_TASK, 2'b11, 16'hFFFF, 16'hCAFE);
    host_read(SP_TASK, LANE_EVEN, 11'h001);
    check_word({8'h00, got[7:0]}, 16'h003E);
    host_read(SP_TASK, LANE_WORD, 11'h000);
    check_word(got, 16'h5A3F);
    // Alternate register block through the second select
    host_read(SP_TASK, LANE_EVEN, 11'h00E);
    check_word({8'h00, got[7:0]}, 16'h0031);
    print_verdict();
  end
endmodule
`default_nettype wire
